// file: src/cdc_cfg_top.sv
// Overview of operation
// - Rate field 000..011 selects 848/424/212/106 kBd encoder clock.
// - Modulation pulse lasts 2*(width+1) system clock cycles.
// - Pulse field 000..100 selects 1,2,4,8,16 subcarrier pulses.
// - Bit 2 of receiver control switches the low-pass filter off.
// - Gain field selects 20, 24, 31 or 35 dB.
// - Multi-frame bit zero: receiver stops after one frame.
// - Multi-frame bit one: receiver stays on across frames.
// - Mask bit one: bits after a collision forced to zero.
// - Line-code bit selects Manchester (0) or BPSK (1) decoding.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module cdc_cfg_top #(
  parameter int AW = 8
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          mod_start,
  output logic               mod_pulse,
  output logic               enc_bit_tick,
  output logic [2:0]         encoder_rate_sel,
  output logic [4:0]         subcarrier_pulses_per_bit,
  output logic               lowpass_disable,
  output logic [1:0]         rx_gain_sel,
  output logic               rx_line_code_sel,
  input  wire logic          rx_start,
  input  wire logic          rx_stop,
  input  wire logic          rx_frame_start,
  input  wire logic          rx_frame_end,
  output logic               rx_active,
  input  wire logic          manch_bit_valid,
  input  wire logic          manch_bit,
  input  wire logic          manch_coll,
  input  wire logic          bpsk_bit_valid,
  input  wire logic          bpsk_bit,
  output logic               rx_bit_valid,
  output logic               rx_bit,
  output logic               rx_coll_seen
);

  logic [7:0] tx_reserved_preset_a;
  logic [7:0] encoder_rate_control;
  logic [7:0] modulation_pulse_width;
  logic [7:0] tx_reserved_preset_b;
  logic [7:0] tx_reserved_preset_c;
  logic [7:0] receiver_gain_pulse_control;
  logic [7:0] decoder_mode_control;

  logic [AW-1:0] aw_addr;
  logic          aw_held;
  logic [7:0]    w_byte;
  logic          w_lane0;
  logic          w_held;
  logic          do_write;
  logic [5:0]    wr_idx;
  logic [5:0]    rd_idx;
  logic [8:0]    etu_cnt;
  logic [8:0]    etu_div;
  logic          multi_frame_receive;
  logic          mask_after_collision;
  logic          pick_valid;
  logic          pick_bit;
  logic          pick_coll;

  function automatic logic cdc_mapped(input logic [5:0] idx);
    case (idx)
      cdc_cfg_pkg::IDX_PRESET_A,
      cdc_cfg_pkg::IDX_ENC_RATE,
      cdc_cfg_pkg::IDX_MOD_WIDTH,
      cdc_cfg_pkg::IDX_PRESET_B,
      cdc_cfg_pkg::IDX_PRESET_C,
      cdc_cfg_pkg::IDX_RX_GAIN,
      cdc_cfg_pkg::IDX_DEC_MODE: cdc_mapped = 1'h1;
      default:                   cdc_mapped = 1'h0;
    endcase
  endfunction

  function automatic logic [5:0] cdc_index(input logic [AW-1:0] addr);
    cdc_index = addr[7:2];
  endfunction

  function automatic logic [8:0] cdc_etu(input logic [2:0] rate);
    logic [8:0] base;
    base = 9'(cdc_cfg_pkg::ETU_106_CYC);
    cdc_etu = base >> (cdc_cfg_pkg::RATE_106 - rate);
  endfunction

  assign wr_idx   = cdc_index(aw_addr);
  assign rd_idx   = cdc_index(s_axi_araddr);
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign etu_div  = cdc_etu(encoder_rate_sel);
  assign multi_frame_receive  =
    decoder_mode_control[cdc_cfg_pkg::MULTI_BIT];
  assign mask_after_collision =
    decoder_mode_control[cdc_cfg_pkg::MASK_BIT];

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'h1;
      aw_held       <= 1'h0;
      aw_addr       <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'h0;
      aw_held       <= 1'h1;
      aw_addr       <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'h1;
      aw_held       <= 1'h0;
    end
  end

  // Write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'h1;
      w_held       <= 1'h0;
      w_byte       <= 8'h00;
      w_lane0      <= 1'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'h0;
      w_held       <= 1'h1;
      w_byte       <= s_axi_wdata[7:0];
      w_lane0      <= s_axi_wstrb[0];
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'h1;
      w_held       <= 1'h0;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'h0;
      s_axi_bresp  <= cdc_cfg_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'h1;
      s_axi_bresp  <= cdc_mapped(wr_idx) ? cdc_cfg_pkg::RESP_OKAY
                                         : cdc_cfg_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_reserved_preset_a        <= cdc_cfg_pkg::RST_PRESET_A;
      encoder_rate_control        <= cdc_cfg_pkg::RST_ENC_RATE;
      modulation_pulse_width      <= cdc_cfg_pkg::RST_MOD_WIDTH;
      tx_reserved_preset_b        <= cdc_cfg_pkg::RST_PRESET_B;
      tx_reserved_preset_c        <= cdc_cfg_pkg::RST_PRESET_C;
      receiver_gain_pulse_control <= cdc_cfg_pkg::RST_RX_GAIN;
      decoder_mode_control        <= cdc_cfg_pkg::RST_DEC_MODE;
    end else if (do_write && w_lane0) begin
      case (wr_idx)
        cdc_cfg_pkg::IDX_PRESET_A:  tx_reserved_preset_a   <= w_byte;
        cdc_cfg_pkg::IDX_ENC_RATE:  encoder_rate_control   <= w_byte;
        cdc_cfg_pkg::IDX_MOD_WIDTH: modulation_pulse_width <= w_byte;
        cdc_cfg_pkg::IDX_PRESET_B:  tx_reserved_preset_b   <= w_byte;
        cdc_cfg_pkg::IDX_PRESET_C:  tx_reserved_preset_c   <= w_byte;
        cdc_cfg_pkg::IDX_RX_GAIN: begin
          receiver_gain_pulse_control <= w_byte;
        end
        cdc_cfg_pkg::IDX_DEC_MODE:  decoder_mode_control   <= w_byte;
        default: begin
        end
      endcase
    end
  end

  // Read channel, one transfer at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'h1;
      s_axi_rvalid  <= 1'h0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= cdc_cfg_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid  <= 1'h1;
      s_axi_rresp   <= cdc_mapped(rd_idx) ? cdc_cfg_pkg::RESP_OKAY
                                          : cdc_cfg_pkg::RESP_SLVERR;
      case (rd_idx)
        cdc_cfg_pkg::IDX_PRESET_A:
          s_axi_rdata <= {24'h000000, tx_reserved_preset_a};
        cdc_cfg_pkg::IDX_ENC_RATE:
          s_axi_rdata <= {24'h000000, encoder_rate_control};
        cdc_cfg_pkg::IDX_MOD_WIDTH:
          s_axi_rdata <= {24'h000000, modulation_pulse_width};
        cdc_cfg_pkg::IDX_PRESET_B:
          s_axi_rdata <= {24'h000000, tx_reserved_preset_b};
        cdc_cfg_pkg::IDX_PRESET_C:
          s_axi_rdata <= {24'h000000, tx_reserved_preset_c};
        cdc_cfg_pkg::IDX_RX_GAIN:
          s_axi_rdata <= {24'h000000, receiver_gain_pulse_control};
        cdc_cfg_pkg::IDX_DEC_MODE:
          s_axi_rdata <= {24'h000000, decoder_mode_control};
        default:
          s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'h1;
      s_axi_rvalid  <= 1'h0;
    end
  end

  // Configuration outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Fields of the register reset values
      encoder_rate_sel          <=
        cdc_cfg_pkg::RST_ENC_RATE[cdc_cfg_pkg::ENC_RATE_LSB +: 3];
      subcarrier_pulses_per_bit <=
        5'h01 << cdc_cfg_pkg::RST_RX_GAIN[cdc_cfg_pkg::SUBC_LSB +: 3];
      lowpass_disable           <=
        cdc_cfg_pkg::RST_RX_GAIN[cdc_cfg_pkg::LOWPASS_DISABLE_BIT];
      rx_gain_sel               <=
        cdc_cfg_pkg::RST_RX_GAIN[cdc_cfg_pkg::GAIN_LSB +: 2];
      rx_line_code_sel          <=
        cdc_cfg_pkg::RST_DEC_MODE[cdc_cfg_pkg::CODE_BIT];
    end else begin
      encoder_rate_sel <=
        encoder_rate_control[cdc_cfg_pkg::ENC_RATE_LSB +: 3];
      // pulses per bit, zero if reserved
      if (receiver_gain_pulse_control[cdc_cfg_pkg::SUBC_LSB +: 3]
          <= cdc_cfg_pkg::SUBC_MAX) begin
        subcarrier_pulses_per_bit <= 5'h01 <<
          receiver_gain_pulse_control[cdc_cfg_pkg::SUBC_LSB +: 3];
      end else begin
        subcarrier_pulses_per_bit <= 5'h00;
      end
      lowpass_disable <=
        receiver_gain_pulse_control[cdc_cfg_pkg::LOWPASS_DISABLE_BIT];
      rx_gain_sel <=
        receiver_gain_pulse_control[cdc_cfg_pkg::GAIN_LSB +: 2];
      rx_line_code_sel <= decoder_mode_control[cdc_cfg_pkg::CODE_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      etu_cnt      <= 9'h000;
      enc_bit_tick <= 1'h0;
    end else if (encoder_rate_sel > cdc_cfg_pkg::RATE_106) begin
      etu_cnt      <= 9'h000;
      enc_bit_tick <= 1'h0;
    end else if (etu_cnt >= etu_div - 9'h001) begin
      etu_cnt      <= 9'h000;
      enc_bit_tick <= 1'h1;
    end else begin
      etu_cnt      <= etu_cnt + 9'h001;
      enc_bit_tick <= 1'h0;
    end
  end

  cdc_mod_pulse u_mod_pulse (
    .aclk    (aclk),
    .aresetn (aresetn),
    .width   (modulation_pulse_width),
    .start   (mod_start),
    .pulse   (mod_pulse)
  );

  // Receiver on/off; start wins over a stop in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_active <= 1'h0;
    end else if (rx_start) begin
      rx_active <= 1'h1;
    end else if (rx_stop) begin
      rx_active <= 1'h0;
    end else if (rx_frame_end && !multi_frame_receive) begin
      rx_active <= 1'h0;
    end
  end

  always_comb begin
    if (decoder_mode_control[cdc_cfg_pkg::CODE_BIT]) begin
      pick_valid = bpsk_bit_valid;
      pick_bit   = bpsk_bit;
      pick_coll  = 1'h0;
    end else begin
      pick_valid = manch_bit_valid;
      pick_bit   = manch_bit;
      pick_coll  = manch_coll;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_bit_valid <= 1'h0;
      rx_bit       <= 1'h0;
      rx_coll_seen <= 1'h0;
    end else begin
      rx_bit_valid <= pick_valid && rx_active;
      if (pick_valid && rx_active) begin
        rx_bit <= pick_bit && !(mask_after_collision && rx_coll_seen);
      end
      if (pick_valid && rx_active && pick_coll) begin
        rx_coll_seen <= 1'h1;
      end else if (rx_frame_start) begin
        rx_coll_seen <= 1'h0;
      end
    end
  end

endmodule

// file: src/cdc_cfg_pkg.sv
package cdc_cfg_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_PRESET_A   = 6'h13;
  localparam logic [5:0] IDX_ENC_RATE   = 6'h14;
  localparam logic [5:0] IDX_MOD_WIDTH  = 6'h15;
  localparam logic [5:0] IDX_PRESET_B   = 6'h16;
  localparam logic [5:0] IDX_PRESET_C   = 6'h17;
  localparam logic [5:0] IDX_RX_GAIN    = 6'h19;
  localparam logic [5:0] IDX_DEC_MODE   = 6'h1A;

  // Reset values
  localparam logic [7:0] RST_PRESET_A   = 8'h3F;
  localparam logic [7:0] RST_ENC_RATE   = 8'h19;
  localparam logic [7:0] RST_MOD_WIDTH  = 8'h13;
  localparam logic [7:0] RST_PRESET_B   = 8'h00;
  localparam logic [7:0] RST_PRESET_C   = 8'h00;
  localparam logic [7:0] RST_RX_GAIN    = 8'h73;
  localparam logic [7:0] RST_DEC_MODE   = 8'h08;

  // Field positions
  localparam int ENC_RATE_LSB  = 3;
  localparam int SUBC_LSB      = 5;
  localparam int LOWPASS_DISABLE_BIT     = 2;
  localparam int GAIN_LSB      = 0;
  localparam int MULTI_BIT     = 6;
  localparam int MASK_BIT      = 5;
  localparam int CODE_BIT      = 0;

  // Encoder rate codes and largest pulse field code
  localparam logic [2:0] RATE_848 = 3'h0;
  localparam logic [2:0] RATE_106 = 3'h3;
  localparam logic [2:0] SUBC_MAX = 3'h4;

  // Bit period at the slowest encoder rate
  localparam int CLK_KHZ       = 40000;
  localparam int ETU_106_NS    = 9440;
  localparam int ETU_106_CYC   = ETU_106_NS * CLK_KHZ / 1000000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: src/cdc_mod_pulse.sv
`timescale 1ns/1ps
module cdc_mod_pulse (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] width,
  input  wire logic       start,
  output logic            pulse
);

  logic [8:0] remain;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse  <= 1'h0;
      remain <= 9'h000;
    end else if (!pulse) begin
      if (start) begin
        pulse  <= 1'h1;
        remain <= {width, 1'h1};
      end
    end else if (remain == 9'h000) begin
      pulse <= 1'h0;
    end else begin
      remain <= remain - 9'h001;
    end
  end

endmodule

// file: dv/cdc_cfg_assertions.sv
`timescale 1ns/1ps
module cdc_cfg_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        mod_pulse,
  input wire logic        enc_bit_tick,
  input wire logic [4:0]  subcarrier_pulses_per_bit,
  input wire logic        rx_start,
  input wire logic        rx_active,
  input wire logic        rx_bit_valid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [9:0] hi_cnt;
  // Length of the current modulation pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) hi_cnt <= 10'h000;
    else hi_cnt <= mod_pulse ? hi_cnt + 10'h001 : 10'h000;
  end
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  wr_lat_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_awready ##1 s_axi_bvalid) else $error("write answer late");
  rd_lat_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  rd_upper_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  subc_code_a: assert property (
    $onehot0(subcarrier_pulses_per_bit)) else $error("bad pulse count");
  tick_gap_a: assert property (
    enc_bit_tick |=> !enc_bit_tick [*2]) else $error("ticks too close");
  pulse_even_a: assert property (
    $fell(mod_pulse) |-> !hi_cnt[0] && hi_cnt >= 10'h002)
    else $error("odd pulse length");
  rx_gate_a: assert property (
    !rx_active |=> !rx_bit_valid) else $error("bit while idle");
  start_on_a: assert property (
    rx_start |=> rx_active) else $error("receiver not started");
  wr_c: cover property (s_axi_bvalid && s_axi_bready);
  pulse_c: cover property ($fell(mod_pulse));
  bit_c: cover property (rx_bit_valid);
endmodule

bind cdc_cfg_top cdc_cfg_checker chk_i (.*);

// file: dv/coder_decoder_config_tb_top.sv
`timescale 1ns/1ps
module coder_decoder_config_tb_top;
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, mod_start = 1'h0;
  logic        rx_start = 1'h0, rx_stop = 1'h0;
  logic        rx_frame_start = 1'h0, rx_frame_end = 1'h0;
  logic        manch_bit_valid = 1'h0, manch_bit = 1'h0;
  logic        manch_coll = 1'h0, bpsk_bit_valid = 1'h0;
  logic        bpsk_bit = 1'h0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        mod_pulse, enc_bit_tick, lowpass_disable;
  logic        rx_line_code_sel, rx_active, rx_bit_valid;
  logic        rx_bit, rx_coll_seen;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rx_gain_sel;
  logic [2:0]  encoder_rate_sel;
  logic [4:0]  subcarrier_pulses_per_bit;
  int          mismatches = 0, comparisons = 0, cycles = 0;

  cdc_cfg_top #(.AW(8)) DUT (.*);

  initial begin
    forever #12.5 aclk = ~aclk;
  end

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [5:0] i, input logic [7:0] d,
                     input logic [1:0] er = cdc_cfg_pkg::RESP_OKAY);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'hA5A5A5, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1) break;
    end
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, er);
    repeat (2) @(posedge aclk);
  endtask

  task automatic axr(input logic [5:0] i, input logic [7:0] ed,
                     input logic [1:0] er = cdc_cfg_pkg::RESP_OKAY);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1) break;
    end
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, {24'h0, ed});
    chk(s_axi_rresp, er);
    @(posedge aclk);
  endtask

  // Pulse start, stop, frame start, frame end
  task automatic ctl(input logic [3:0] p);
    {rx_start, rx_stop, rx_frame_start, rx_frame_end} <= p;
    @(posedge aclk);
    {rx_start, rx_stop, rx_frame_start, rx_frame_end} <= 4'h0;
    repeat (2) @(posedge aclk);
  endtask

  task automatic bit_in(input logic m, c, b, e);
    manch_bit <= m;
    manch_coll <= c;
    bpsk_bit <= b;
    manch_bit_valid <= 1'h1;
    bpsk_bit_valid <= 1'h1;
    @(posedge aclk);
    manch_bit_valid <= 1'h0;
    bpsk_bit_valid <= 1'h0;
    manch_coll <= 1'h0;
    @(posedge aclk);
    chk(rx_bit_valid, 1'h1);
    chk(rx_bit, e);
  endtask

  task automatic t_reset();
    axr(cdc_cfg_pkg::IDX_PRESET_A, cdc_cfg_pkg::RST_PRESET_A);
    axr(cdc_cfg_pkg::IDX_ENC_RATE, cdc_cfg_pkg::RST_ENC_RATE);
    axr(cdc_cfg_pkg::IDX_MOD_WIDTH, cdc_cfg_pkg::RST_MOD_WIDTH);
    axr(cdc_cfg_pkg::IDX_PRESET_B, cdc_cfg_pkg::RST_PRESET_B);
    axr(cdc_cfg_pkg::IDX_PRESET_C, cdc_cfg_pkg::RST_PRESET_C);
    axr(cdc_cfg_pkg::IDX_RX_GAIN, cdc_cfg_pkg::RST_RX_GAIN);
    axr(cdc_cfg_pkg::IDX_DEC_MODE, cdc_cfg_pkg::RST_DEC_MODE);
    axr(6'h18, 8'h00, cdc_cfg_pkg::RESP_SLVERR);
    axw(6'h18, 8'hFF, cdc_cfg_pkg::RESP_SLVERR);
    // Lane 0 disabled: write must be dropped
    s_axi_wstrb <= 4'hE;
    axw(cdc_cfg_pkg::IDX_MOD_WIDTH, 8'h55);
    s_axi_wstrb <= 4'hF;
    axr(cdc_cfg_pkg::IDX_MOD_WIDTH, cdc_cfg_pkg::RST_MOD_WIDTH);
    chk(encoder_rate_sel, 3'h3);
    chk(subcarrier_pulses_per_bit, 5'h08);
    chk(rx_gain_sel, 2'h3);
  endtask

  task automatic t_rate();
    int n;
    for (int r = 0; r < 5; r++) begin
      axw(cdc_cfg_pkg::IDX_ENC_RATE, {2'h0, r[2:0], 3'h1});
      chk(encoder_rate_sel, r);
      n = 0;
      if (r < 4) begin
        do @(posedge aclk); while (enc_bit_tick !== 1'h1);
        do begin
          @(posedge aclk);
          n++;
        end while (enc_bit_tick !== 1'h1);
        chk(n, cdc_cfg_pkg::ETU_106_CYC >> (3 - r));
      end else begin
        repeat (400) begin
          @(posedge aclk);
          n += (enc_bit_tick !== 1'h0);
        end
        chk(n, 0);
      end
    end
    axw(cdc_cfg_pkg::IDX_ENC_RATE, cdc_cfg_pkg::RST_ENC_RATE);
  endtask

  task automatic t_mod(input logic [7:0] w);
    int n;
    n = 0;
    axw(cdc_cfg_pkg::IDX_MOD_WIDTH, w);
    axr(cdc_cfg_pkg::IDX_MOD_WIDTH, w);
    mod_start <= 1'h1;
    @(posedge aclk);
    mod_start <= 1'h0;
    do @(posedge aclk); while (mod_pulse !== 1'h1);
    while (mod_pulse === 1'h1) begin
      n++;
      @(posedge aclk);
    end
    chk(n, 2 * (w + 1));
  endtask

  task automatic t_rxcfg();
    logic [7:0] v;
    for (int i = 0; i < 6; i++) begin
      v = {i[2:0], 2'h2, i[0], i[1:0]};
      axw(cdc_cfg_pkg::IDX_RX_GAIN, v);
      axr(cdc_cfg_pkg::IDX_RX_GAIN, v);
      chk(subcarrier_pulses_per_bit, i < 5 ? 1 << i : 0);
      chk(lowpass_disable, i[0]);
      chk(rx_gain_sel, i[1:0]);
    end
  endtask

  task automatic t_rx();
    axw(cdc_cfg_pkg::IDX_DEC_MODE, 8'h28);
    ctl(4'h8);
    bit_in(1'h1, 1'h0, 1'h0, 1'h1);
    bit_in(1'h1, 1'h1, 1'h0, 1'h1);
    bit_in(1'h1, 1'h0, 1'h0, 1'h0);
    chk(rx_coll_seen, 1'h1);
    ctl(4'h2);
    chk(rx_coll_seen, 1'h0);
    bit_in(1'h1, 1'h0, 1'h0, 1'h1);
    ctl(4'h1);
    chk(rx_active, 1'h0);
    // Masking off: bits after a collision pass unchanged
    axw(cdc_cfg_pkg::IDX_DEC_MODE, 8'h48);
    ctl(4'h8);
    bit_in(1'h1, 1'h1, 1'h0, 1'h1);
    bit_in(1'h1, 1'h0, 1'h0, 1'h1);
    axw(cdc_cfg_pkg::IDX_DEC_MODE, 8'h49);
    ctl(4'h8);
    bit_in(1'h0, 1'h0, 1'h1, 1'h1);
    bit_in(1'h1, 1'h0, 1'h0, 1'h0);
    chk(rx_line_code_sel, 1'h1);
    ctl(4'h1);
    chk(rx_active, 1'h1);
    ctl(4'h4);
    chk(rx_active, 1'h0);
    axr(cdc_cfg_pkg::IDX_DEC_MODE, 8'h49);
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset();
    t_rate();
    t_mod(8'h00);
    t_mod(8'h03);
    t_mod(8'hFF);
    t_rxcfg();
    t_rx();
    // Reset in mid-run restores every register
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset();
    give_verdict();
  end
endmodule
